// ===== include/opmode_consts.vh
// Constants for the operating mode controller
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH
// Operating mode state codes
`define MODE_INIT      3'h0
`define MODE_NORMAL    3'h1
`define MODE_STOP      3'h2
`define MODE_SLEEP     3'h3
`define MODE_RESTART   3'h4
// Mode request field of a mode command
`define MREQ_NORMAL    2'h0
`define MREQ_SLEEP     2'h1
`define MREQ_STOP      2'h2
`define MREQ_SOFT_RST  2'h3
// Command targets
`define TGT_MODE       3'h0
`define TGT_WD         3'h1
`define TGT_HS         3'h2
`define TGT_BDCP       3'h3
`define TGT_CAN        3'h4
`define TGT_CYC_SENSE  3'h5
`define TGT_CYC_WAKE   3'h6
`define TGT_STATUS     3'h7
// CAN transceiver states
`define CAN_OFF        2'h0
`define CAN_WAKE_CAP   2'h1
`define CAN_ON         2'h2
`define CAN_WOKEN      2'h3
// Cyclic time bases
`define TB_TIMER1      2'h0
`define TB_TIMER2      2'h1
`define TB_SYNC        2'h2
// Field positions inside cmd_data
`define CS_EN_BIT      0
`define CS_TB_LSB      1
`define CW_EN_BIT      0
`define CW_TB_BIT      1
`define BD_EN_BIT      0
`define CP_EN_BIT      1
// Soft reset and power-up values
`define WD_CFG_RST     8'h00
`define HS_CFG_RST     4'h0
`define BDCP_CFG_RST   2'h0
`define CAN_CFG_RST    2'h0
`define CS_CFG_RST     3'h0
`define CW_CFG_RST     2'h0
`endif

// ===== core/operating_mode_controller.v
// Operating mode controller: mode state, configuration gating, function enables
// Functional notes
// R01: Enter Init once supply passes power-on threshold
// R02: Watchdog runs long window after reset release; only in Init here, not on the release after Restart
// R03: Watchdog configuration locked in Init
// R04: Init: regulator on, all functions off
// R05: Init: CAN off unless software development mode
// R06: Normal: all functions configurable and switchable
// R07: Normal: cyclic sense timer1, timer2 or sync
// R08: Normal: cyclic wake timer1 or timer2
// R09: Stop: reject writes, flag error, with exceptions
// R10: Stop: wake events raise masked interrupt only
// R11: Stop: regulator low power, bridge, pump off
// R12: Stop: configuration frozen from Normal mode
// R13: Host configures everything before low-power entry
// R14: Stop/Sleep: low-side braking still allowed
// R15: Sleep: regulator, watchdog, bridge, pump off
// R16: Sleep: CAN wake-capable or off per config
// R17: Restart: reset output held low throughout
// R18: Restart: disable watchdog, switches, cyclic functions
// R19: Restart: regulator on or ramping up
// R20: Restart: CAN woken, wake-capable or off
// R21: Init: any valid command moves to Normal
// R22: Soft reset from Normal/Stop returns Init
// R23: Single synchronous mode register, one mode
// R24: Enables derived from mode and configuration
`include "opmode_consts.vh"
module operating_mode_controller (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Supply supervision
    input  wire       por_ok,          // Supply above power-on threshold
    input  wire       reg_good,        // Main regulator above reset threshold
    // Command path, one pulse per protocol-valid frame
    input  wire       cmd_valid,
    input  wire       cmd_write,
    input  wire [2:0] cmd_target,
    input  wire [7:0] cmd_data,
    // Events from the rest of the device
    input  wire       restart_req,     // Failure needing a host reset
    input  wire       sleep_wake,      // Wake event while sleeping
    input  wire       can_bus_wake,    // Wake-up seen on the CAN bus
    input  wire       wake_event,      // Any wake source while stopped
    input  wire       wake_int_mask,   // High lets wake events interrupt
    input  wire       brake_req,       // Parking or overvoltage brake request
    input  wire       sdm_strap,       // Test pin pulled low selects SDM
    // Mode and reset toward the host
    output reg  [2:0] mode_q,
    output reg        reset_out_n,
    output reg        int_out_n,
    output reg        cmd_error_q,
    output reg        sdm_q,
    // Function enables
    output reg        main_supply_regulator_on,
    output reg        regulator_low_power,
    output reg        watchdog_timer_run,
    output reg        long_open_window,
    output reg  [7:0] watchdog_cfg,
    output reg  [3:0] high_side_switches,
    output reg        bridge_drivers,
    output reg        charge_pump,
    output reg        low_side_brake,
    output reg  [1:0] can_state,
    output reg        cyc_sense_en,
    output reg  [1:0] cyc_sense_tb,
    output reg        cyc_wake_en,
    output reg  [1:0] cyc_wake_tb
);
    // Stored configuration
    reg  [7:0] wd_cfg_q;               // Watchdog settings
    reg  [3:0] hs_cfg_q;               // High-side switch on bits
    reg  [1:0] bdcp_cfg_q;             // Bridge and pump enables
    reg  [1:0] can_cfg_q;              // CAN state chosen by host
    reg  [2:0] cs_cfg_q;               // Cyclic sense enable and base
    reg  [1:0] cw_cfg_q;               // Cyclic wake enable and base
    reg        can_woke_q;             // Bus wake seen during restart
    reg        int_req_q;              // Pending wake interrupt
    reg        rst_rel_q;              // Reset released since power-up or Restart
    // Next values
    reg  [2:0] mode_d;
    reg  [7:0] wd_cfg_d;
    reg  [3:0] hs_cfg_d;
    reg  [1:0] bdcp_cfg_d;
    reg  [1:0] can_cfg_d;
    reg  [2:0] cs_cfg_d;
    reg  [1:0] cw_cfg_d;
    reg        err_set;
    reg        sdm_d;
    // Decoded command
    wire       is_mode = cmd_valid && cmd_write && (cmd_target == `TGT_MODE);
    wire [1:0] mreq    = cmd_data[1:0];
    wire       is_clr  = cmd_valid && cmd_write && (cmd_target == `TGT_STATUS);
    // True for a write that only a configurable mode may take
    function cfg_write;
        input       v;
        input       w;
        input [2:0] t;
        begin
            cfg_write = v && w && (t != `TGT_MODE) && (t != `TGT_STATUS);
        end
    endfunction
    // Cyclic sense base must be one of the three legal sources
    function tb_ok;
        input [1:0] tb;
        begin
            tb_ok = (tb != 2'h3);
        end
    endfunction
    wire cfg_wr = cfg_write(cmd_valid, cmd_write, cmd_target);
    // Mode transitions and configuration updates
    always @* begin
        mode_d     = mode_q;
        wd_cfg_d   = wd_cfg_q;
        hs_cfg_d   = hs_cfg_q;
        bdcp_cfg_d = bdcp_cfg_q;
        can_cfg_d  = can_cfg_q;
        cs_cfg_d   = cs_cfg_q;
        cw_cfg_d   = cw_cfg_q;
        err_set    = 1'b0;
        sdm_d      = sdm_q;
        case (mode_q)
            `MODE_INIT: begin
                // Hosts talk only once reset is up; any frame leaves Init
                if (cmd_valid && rst_rel_q) begin
                    mode_d = `MODE_NORMAL;                                  // R21
                    sdm_d  = ~sdm_strap;
                    // Sleep, stop or soft reset requests here are illegal jumps
                    if (is_mode && (mreq != `MREQ_NORMAL))
                        err_set = 1'b1;                                     // R21
                    // Watchdog settings stay at the long window here
                    if (cfg_wr && cmd_target == `TGT_WD)
                        err_set = 1'b1;                                     // R03
                end
            end
            `MODE_NORMAL: begin
                if (restart_req) begin
                    mode_d = `MODE_RESTART;
                end else if (is_mode) begin
                    case (mreq)
                        `MREQ_SLEEP:    mode_d = `MODE_SLEEP;
                        `MREQ_STOP:     mode_d = `MODE_STOP;
                        `MREQ_SOFT_RST: mode_d = `MODE_INIT;                // R22
                        default:        mode_d = `MODE_NORMAL;
                    endcase
                end else if (cfg_wr) begin
                    case (cmd_target)
                        `TGT_WD:   wd_cfg_d   = cmd_data;                   // R06
                        `TGT_HS:   hs_cfg_d   = cmd_data[3:0];              // R06
                        `TGT_BDCP: bdcp_cfg_d = cmd_data[1:0];              // R06
                        `TGT_CAN:  can_cfg_d  = cmd_data[1:0];              // R06
                        `TGT_CYC_SENSE: begin
                            if (tb_ok(cmd_data[`CS_TB_LSB+1:`CS_TB_LSB]))
                                cs_cfg_d = cmd_data[2:0];                   // R07
                            else
                                err_set = 1'b1;                             // R07
                        end
                        `TGT_CYC_WAKE: cw_cfg_d = cmd_data[1:0];            // R08
                        default: err_set = 1'b0;
                    endcase
                end
            end
            `MODE_STOP: begin
                if (restart_req) begin
                    mode_d = `MODE_RESTART;
                end else if (is_mode) begin
                    // Only back to Normal or soft reset are allowed
                    if (mreq == `MREQ_NORMAL)
                        mode_d = `MODE_NORMAL;                              // R09
                    else if (mreq == `MREQ_SOFT_RST)
                        mode_d = `MODE_INIT;                                // R22
                    else
                        err_set = 1'b1;                                     // R09
                end else if (cfg_wr && cmd_target != `TGT_WD) begin
                    // Watchdog refresh passes; other writes are dropped
                    err_set = 1'b1;                                         // R12
                end
            end
            `MODE_SLEEP: begin
                // Regulator is off so no commands arrive; wake restarts
                if (sleep_wake)
                    mode_d = `MODE_RESTART;
            end
            `MODE_RESTART: begin
                // Watchdog, high-side and cyclic settings are dropped on entry
                wd_cfg_d = `WD_CFG_RST;                                     // R18
                hs_cfg_d = `HS_CFG_RST;                                     // R18
                cs_cfg_d = `CS_CFG_RST;                                     // R18
                cw_cfg_d = `CW_CFG_RST;                                     // R18
                if (reg_good && !restart_req)
                    mode_d = `MODE_NORMAL;
            end
            default: mode_d = `MODE_INIT;                                   // R23
        endcase
        // Soft reset restores every setting
        if (mode_d == `MODE_INIT && mode_q != `MODE_INIT) begin
            wd_cfg_d   = `WD_CFG_RST;
            hs_cfg_d   = `HS_CFG_RST;
            bdcp_cfg_d = `BDCP_CFG_RST;
            can_cfg_d  = `CAN_CFG_RST;
            cs_cfg_d   = `CS_CFG_RST;
            cw_cfg_d   = `CW_CFG_RST;
        end
    end
    // Mode register and configuration storage
    always @(posedge mclk) begin
        if (!rst_n || !por_ok) begin
            // Power-up lands in Init with defaults
            mode_q     <= `MODE_INIT;                                       // R01
            wd_cfg_q   <= `WD_CFG_RST;
            hs_cfg_q   <= `HS_CFG_RST;
            bdcp_cfg_q <= `BDCP_CFG_RST;
            can_cfg_q  <= `CAN_CFG_RST;
            cs_cfg_q   <= `CS_CFG_RST;
            cw_cfg_q   <= `CW_CFG_RST;
            sdm_q      <= 1'b0;
        end else begin
            mode_q     <= mode_d;                                           // R23
            wd_cfg_q   <= wd_cfg_d;
            hs_cfg_q   <= hs_cfg_d;
            bdcp_cfg_q <= bdcp_cfg_d;
            can_cfg_q  <= can_cfg_d;
            cs_cfg_q   <= cs_cfg_d;
            cw_cfg_q   <= cw_cfg_d;
            sdm_q      <= sdm_d;
        end
    end
    // Reset release tracking, bus wake capture, sticky flags
    always @(posedge mclk) begin
        if (!rst_n || !por_ok) begin
            rst_rel_q   <= 1'b0;
            can_woke_q  <= 1'b0;
            int_req_q   <= 1'b0;
            cmd_error_q <= 1'b0;
        end else begin
            // Reset drops again in Restart; Init waits for the regulator
            if (mode_q == `MODE_RESTART)
                rst_rel_q <= 1'b0;                                          // R17
            else if (reg_good)
                rst_rel_q <= 1'b1;
            // Bus wake during restart shows as woken
            if (mode_q == `MODE_RESTART && can_bus_wake)
                can_woke_q <= 1'b1;                                         // R20
            else if (mode_q != `MODE_RESTART)
                can_woke_q <= 1'b0;
            // Set wins over a clear in the same cycle
            if (mode_q == `MODE_STOP && wake_event && wake_int_mask)
                int_req_q <= 1'b1;                                          // R10
            else if (is_clr)
                int_req_q <= 1'b0;
            if (err_set)
                cmd_error_q <= 1'b1;                                        // R09
            else if (is_clr)
                cmd_error_q <= 1'b0;
        end
    end
    // Combinational enables from mode and configuration
    reg        reg_on_d;
    reg        reg_lp_d;
    reg        wd_run_d;
    reg        lw_d;
    reg  [3:0] hs_d;
    reg        bd_d;
    reg        cp_d;
    reg        brk_d;
    reg  [1:0] can_d;
    reg        cs_d;
    reg        cw_d;
    reg        rst_out_d;
    always @* begin
        reg_on_d  = 1'b1;
        reg_lp_d  = 1'b0;
        wd_run_d  = 1'b0;
        lw_d      = 1'b0;
        hs_d      = 4'h0;
        bd_d      = 1'b0;
        cp_d      = 1'b0;
        brk_d     = 1'b0;
        can_d     = `CAN_OFF;
        cs_d      = 1'b0;
        cw_d      = 1'b0;
        rst_out_d = rst_rel_q;
        case (mode_q)
            `MODE_INIT: begin
                // Only the regulator, the long window and, with sdm_strap low, CAN run
                wd_run_d = rst_rel_q; // R02
                lw_d     = 1'b1; // R03
                can_d    = sdm_strap ? `CAN_OFF : `CAN_ON; // R05
            end
            `MODE_NORMAL: begin
                wd_run_d = 1'b1; // R24
                hs_d     = hs_cfg_q; // R06
                bd_d     = bdcp_cfg_q[`BD_EN_BIT]; // R06
                cp_d     = bdcp_cfg_q[`CP_EN_BIT]; // R06
                can_d    = sdm_q && (can_cfg_q == `CAN_OFF) ? `CAN_ON : can_cfg_q;
                cs_d     = cs_cfg_q[`CS_EN_BIT]; // R07
                cw_d     = cw_cfg_q[`CW_EN_BIT]; // R08
            end
            `MODE_STOP: begin
                // Regulator stays on at low quiescent current
                reg_lp_d = 1'b1; // R11
                wd_run_d = 1'b1; // R12
                hs_d     = hs_cfg_q; // R12
                can_d    = can_cfg_q; // R12
                cs_d     = cs_cfg_q[`CS_EN_BIT]; // R12
                cw_d     = cw_cfg_q[`CW_EN_BIT]; // R12
                brk_d    = brake_req; // R14
            end
            `MODE_SLEEP: begin
                reg_on_d = 1'b0; // R15
                hs_d     = hs_cfg_q; // R15
                cs_d     = cs_cfg_q[`CS_EN_BIT]; // R15
                cw_d     = cw_cfg_q[`CW_EN_BIT]; // R15
                // Only wake detection survives, never a full transceiver
                can_d    = (can_cfg_q == `CAN_OFF) ? `CAN_OFF : `CAN_WAKE_CAP; // R16
                brk_d    = brake_req; // R14
            end
            `MODE_RESTART: begin
                // Regulator may still be ramping; reset held low
                reg_on_d  = 1'b1; // R19
                rst_out_d = 1'b0; // R17
                if (can_woke_q)
                    can_d = `CAN_WOKEN; // R20
                else
                    can_d = (can_cfg_q == `CAN_OFF) ? `CAN_OFF : `CAN_WAKE_CAP; // R20
            end
            default: reg_on_d = 1'b1;
        endcase
    end
    // Registered outputs; one cycle behind the mode register
    always @(posedge mclk) begin
        if (!rst_n || !por_ok) begin
            reset_out_n              <= 1'b0;
            int_out_n                <= 1'b1;
            main_supply_regulator_on <= 1'b0;
            regulator_low_power      <= 1'b0;
            watchdog_timer_run       <= 1'b0;
            long_open_window         <= 1'b0;
            watchdog_cfg             <= `WD_CFG_RST;
            high_side_switches       <= 4'h0;
            bridge_drivers           <= 1'b0;
            charge_pump              <= 1'b0;
            low_side_brake           <= 1'b0;
            can_state                <= `CAN_OFF;
            cyc_sense_en             <= 1'b0;
            cyc_sense_tb             <= `TB_TIMER1;
            cyc_wake_en              <= 1'b0;
            cyc_wake_tb              <= `TB_TIMER1;
        end else begin
            reset_out_n              <= rst_out_d; // R17
            int_out_n                <= ~int_req_q; // R10
            main_supply_regulator_on <= reg_on_d; // R04
            regulator_low_power      <= reg_lp_d; // R11
            watchdog_timer_run       <= wd_run_d; // R02
            long_open_window         <= lw_d; // R02
            watchdog_cfg             <= wd_cfg_q;
            high_side_switches       <= hs_d; // R24
            bridge_drivers           <= bd_d; // R11
            charge_pump              <= cp_d; // R11
            low_side_brake           <= brk_d; // R14
            can_state                <= can_d; // R24
            cyc_sense_en             <= cs_d; // R24
            cyc_sense_tb             <= cs_cfg_q[`CS_TB_LSB+1:`CS_TB_LSB]; // R07
            cyc_wake_en              <= cw_d; // R24
            cyc_wake_tb              <= {1'b0, cw_cfg_q[`CW_TB_BIT]}; // R08
        end
    end
endmodule // operating_mode_controller

// ===== tb/opmode_host.sv
// Host-side model driving command frames into the mode controller
module opmode_host (
    // Clock and device reset
    input  wire logic       mclk,
    input  wire logic       reset_out_n,
    // Command frame toward the device
    output logic       cmd_valid,
    output logic       cmd_write,
    output logic [2:0] cmd_target,
    output logic [7:0] cmd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {cmd_valid, cmd_write, cmd_target, cmd_data} = '0;
    // Idle fields flip each cycle so stale values are never trusted
    always @(posedge mclk) begin
        if (!cmd_valid) begin
            cmd_write  <= ~cmd_write;
            cmd_target <= ~cmd_target;
            cmd_data   <= ~cmd_data;
        end
    end
    // One frame, one cycle, once the host is out of reset or after 200 cycles of waiting
    task automatic send(input logic w, input logic [2:0] t, input logic [7:0] d);
        for (int n = 0; n < 200 && reset_out_n !== 1'b1; n++) @(posedge mclk);
        @(posedge mclk);
        #2;
        {cmd_valid, cmd_write, cmd_target, cmd_data} = {1'b1, w, t, d};
        @(posedge mclk);
        #2;
        cmd_valid = 1'b0;
    endtask
endmodule // opmode_host

// ===== tb/operating_mode_controller_chk.sv
// Port-level assertions for the operating mode controller
`include "opmode_consts.vh"
module operating_mode_controller_chk (
    // Clock, reset and causes
    input logic       mclk, rst_n, por_ok, cmd_valid, cmd_write, restart_req,
    input logic [2:0] cmd_target,
    input logic [7:0] cmd_data,
    input logic       wake_event, wake_int_mask,
    // Observed outputs
    input logic [2:0] mode_q,
    input logic       reset_out_n, int_out_n, cmd_error_q, main_supply_regulator_on,
    input logic       regulator_low_power, watchdog_timer_run, long_open_window,
    input logic [7:0] watchdog_cfg,
    input logic [3:0] high_side_switches,
    input logic       bridge_drivers, charge_pump, cyc_sense_en, cyc_wake_en,
    input logic [1:0] cyc_sense_tb, cyc_wake_tb
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n || !por_ok);
    // Stop held long enough that pre-entry writes have landed
    sequence s_stop_steady;
        (mode_q == `MODE_STOP) [*3];
    endsequence
    // Unmasked wake while stopped, nothing else competing
    sequence s_stop_wake;
        mode_q == `MODE_STOP && wake_event && wake_int_mask && !cmd_valid && !restart_req;
    endsequence
    a_init_funcs_off: assert property (mode_q == `MODE_INIT |=> main_supply_regulator_on
        && !bridge_drivers && !charge_pump && high_side_switches == 4'h0
        && !cyc_sense_en && !cyc_wake_en) else $error("init function gating wrong");
    a_init_wd_long: assert property (mode_q == `MODE_INIT && reset_out_n
        |=> watchdog_timer_run && long_open_window) else $error("init watchdog wrong");
    a_init_any_cmd: assert property (mode_q == `MODE_INIT && reset_out_n && cmd_valid
        |=> mode_q == `MODE_NORMAL) else $error("init did not leave on frame");
    a_stop_low_power: assert property (mode_q == `MODE_STOP |=> regulator_low_power
        && main_supply_regulator_on && !bridge_drivers && !charge_pump)
        else $error("stop power state wrong");
    a_stop_cfg_frozen: assert property (s_stop_steady |-> $stable({watchdog_cfg,
        high_side_switches, cyc_sense_en, cyc_sense_tb, cyc_wake_en, cyc_wake_tb}))
        else $error("configuration moved in stop");
    a_stop_write_err: assert property (mode_q == `MODE_STOP && cmd_valid && cmd_write
        && cmd_target == `TGT_HS && !restart_req |=> cmd_error_q)
        else $error("stop write not flagged");
    a_stop_wake_int: assert property (s_stop_wake |=> mode_q == `MODE_STOP
        ##[0:1] !int_out_n) else $error("stop wake handling wrong");
    a_sleep_funcs_off: assert property (mode_q == `MODE_SLEEP |=> !watchdog_timer_run
        && !main_supply_regulator_on && !bridge_drivers && !charge_pump)
        else $error("sleep function gating wrong");
    a_restart_reset: assert property (mode_q == `MODE_RESTART |=> !reset_out_n)
        else $error("reset not held in restart");
    a_restart_off: assert property (mode_q == `MODE_RESTART |=> high_side_switches == 4'h0
        && !watchdog_timer_run && !cyc_sense_en && !cyc_wake_en && !bridge_drivers
        && !charge_pump && main_supply_regulator_on) else $error("restart gating wrong");
    a_soft_reset_init: assert property ((mode_q == `MODE_NORMAL || mode_q == `MODE_STOP)
        && cmd_valid && cmd_write && cmd_target == `TGT_MODE && !restart_req
        && cmd_data[1:0] == `MREQ_SOFT_RST |=> mode_q == `MODE_INIT)
        else $error("soft reset did not reach init");
endmodule // operating_mode_controller_chk

// ===== tb/operating_mode_controller_bench.sv
// Self-checking bench for the operating mode controller
`include "opmode_consts.vh"
module operating_mode_controller_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // Clock, reset and device events
    logic mclk = 0, rst_n = 0, por_ok = 1, reg_good = 1, restart_req = 0;
    logic sleep_wake = 0, can_bus_wake = 0, wake_event = 0, wake_int_mask = 0;
    logic brake_req = 0, sdm_strap = 1, cmd_valid, cmd_write;
    logic [2:0] cmd_target, mode_q;
    logic [7:0] cmd_data, watchdog_cfg;
    // Design outputs
    logic reset_out_n, int_out_n, cmd_error_q, sdm_q, main_supply_regulator_on;
    logic regulator_low_power, watchdog_timer_run, long_open_window, bridge_drivers;
    logic charge_pump, low_side_brake, cyc_sense_en, cyc_wake_en;
    logic [3:0] high_side_switches;
    logic [1:0] can_state, cyc_sense_tb, cyc_wake_tb;
    int failures = 0, cmp_count = 0;
    always #12.5 mclk = ~mclk;
    opmode_host i_opmode_host (.*);
    operating_mode_controller i_operating_mode_controller (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Land just after an edge so every update has settled
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic cmd(input logic [2:0] t, input logic [7:0] d);
        i_opmode_host.send(1'b1, t, d);
        step(2);
    endtask
    task automatic t_power_up;
        step(10);
        rst_n = 1;
        step(1);
        chk(mode_q, `MODE_INIT, "init");
        step(3);
        chk(reset_out_n, 1, "reset out");
        chk({watchdog_timer_run, long_open_window}, 2'h3, "long window");
        chk({main_supply_regulator_on, bridge_drivers, charge_pump}, 3'h4, "init power");
        chk(can_state, `CAN_OFF, "init can");
        $display("done: power-up");
    endtask
    task automatic t_init_exit;
        cmd(`TGT_MODE, {6'h00, `MREQ_SLEEP});
        chk(mode_q, `MODE_NORMAL, "init exit");
        chk(cmd_error_q, 1, "init sleep error");
        cmd(`TGT_STATUS, 8'h00);
        chk(cmd_error_q, 0, "error clear");
        $display("done: init exit");
    endtask
    task automatic t_normal_cfg;
        cmd(`TGT_WD, 8'h5a);
        cmd(`TGT_HS, 8'h05);
        cmd(`TGT_BDCP, 8'h03);
        cmd(`TGT_CAN, {6'h00, `CAN_ON});
        chk(watchdog_cfg, 8'h5a, "watchdog config");
        chk({high_side_switches, bridge_drivers, charge_pump}, 6'h17, "switch on");
        chk(can_state, `CAN_ON, "can on");
        for (int b = 0; b < 3; b++) begin
            cmd(`TGT_CYC_SENSE, {5'h00, b[1:0], 1'b1});
            chk({cyc_sense_en, cyc_sense_tb}, {1'b1, b[1:0]}, "sense base");
        end
        cmd(`TGT_CYC_SENSE, 8'h07);
        chk({cmd_error_q, cyc_sense_tb}, {1'b1, `TB_SYNC}, "bad base");
        for (int b = 0; b < 2; b++) begin
            cmd(`TGT_CYC_WAKE, {6'h00, b[0], 1'b1});
            chk({cyc_wake_en, cyc_wake_tb}, {2'h2, b[0]}, "wake base");
        end
        cmd(`TGT_STATUS, 8'h00);
        $display("done: normal config");
    endtask
    task automatic t_stop;
        cmd(`TGT_MODE, {6'h00, `MREQ_STOP});
        chk({regulator_low_power, bridge_drivers, charge_pump}, 3'h4, "stop power");
        cmd(`TGT_HS, 8'h00);
        chk({cmd_error_q, high_side_switches}, 5'h15, "stop write");
        wake_event = 1;
        step(3);
        chk(int_out_n, 1, "masked wake");
        wake_int_mask = 1;
        step(3);
        chk({int_out_n, mode_q}, {1'b0, `MODE_STOP}, "wake interrupt");
        wake_event = 0;
        brake_req = 1;
        step(2);
        chk(low_side_brake, 1, "brake in stop");
        brake_req = 0;
        cmd(`TGT_STATUS, 8'h00);
        chk({int_out_n, cmd_error_q}, 2'h2, "stop clear");
        cmd(`TGT_MODE, {6'h00, `MREQ_NORMAL});
        chk(mode_q, `MODE_NORMAL, "stop to normal");
        $display("done: stop");
    endtask
    task automatic t_sleep_restart;
        cmd(`TGT_MODE, {6'h00, `MREQ_SLEEP});
        reg_good = 0;
        chk({main_supply_regulator_on, watchdog_timer_run, bridge_drivers}, 0, "sleep");
        chk({high_side_switches, can_state}, {4'h5, `CAN_WAKE_CAP}, "sleep kept");
        sleep_wake = 1;
        step(3);
        sleep_wake = 0;
        chk({mode_q, reset_out_n}, {`MODE_RESTART, 1'b0}, "restart");
        chk({high_side_switches, watchdog_timer_run, cyc_sense_en}, 0, "restart off");
        chk(main_supply_regulator_on, 1, "restart reg");
        can_bus_wake = 1;
        step(2);
        chk(can_state, `CAN_WOKEN, "can woken");
        can_bus_wake = 0;
        reg_good = 1;
        for (int n = 0; n < 50 && mode_q !== `MODE_NORMAL; n++) step(1);
        chk(mode_q, `MODE_NORMAL, "restart exit");
        restart_req = 1;
        step(3);
        chk(reset_out_n, 0, "fail restart");
        restart_req = 0;
        for (int n = 0; n < 50 && reset_out_n !== 1'b1; n++) step(1);
        $display("done: sleep and restart");
    endtask
    task automatic t_soft_reset;
        cmd(`TGT_HS, 8'h0a);
        cmd(`TGT_MODE, {6'h00, `MREQ_SOFT_RST});
        chk({mode_q, high_side_switches}, {`MODE_INIT, 4'h0}, "soft reset");
        sdm_strap = 0;
        step(2);
        chk(can_state, `CAN_ON, "sdm can");
        i_opmode_host.send(1'b0, `TGT_STATUS, 8'h00);
        step(1);
        chk({mode_q, sdm_q}, {`MODE_NORMAL, 1'b1}, "read exit");
        sdm_strap = 1;
        $display("done: soft reset");
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        t_power_up();
        t_init_exit();
        t_normal_cfg();
        t_stop();
        t_sleep_restart();
        t_soft_reset();
        end_sim();
    end
    // Tests need well under two hundred cycles; cut a hang far beyond that
    initial begin
        #100us;
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim();
    end
endmodule // operating_mode_controller_bench
bind operating_mode_controller operating_mode_controller_chk i_operating_mode_controller_chk (.*);
